// ===== logic/spi_reg_pkg.sv
// constants shared by both ends of the register access serial link
package spi_reg_pkg;
    // ------------------------------------------------------------------
    // command codes and strap
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ    = 8'h03;
    localparam logic [7:0] CMD_WRITE   = 8'h02;
    localparam logic [1:0] STRAP_SPI   = 2'h2;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W      = 7;
    localparam int         REG_COUNT   = 128;
    localparam logic [6:0] START_REG   = 7'h01;
    localparam int         START_BIT   = 0;
    localparam logic [6:0] TABLE_FIRST = 7'h6E;
    localparam logic [6:0] TABLE_LAST  = 7'h78;
    localparam logic [7:0] REG_RESET   = 8'h00;
    // ------------------------------------------------------------------
    // synchroniser layout {strap[1:0], data in, clock, select_n}
    // ------------------------------------------------------------------
    localparam int         SYNC_W      = 5;
    localparam logic [4:0] SYNC_RESET  = 5'h01;
    localparam int         SY_SEL      = 0;
    localparam int         SY_SCK      = 1;
    localparam int         SY_SDI      = 2;
    localparam int         SY_STRAP    = 3;
    localparam logic [1:0] STRAP_WAIT  = 2'h3;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int         CLK_NS      = 50;
    localparam int         SCK_MIN_NS  = 200;
    localparam int         SCK_HALF_MIN = (SCK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int         HOST_HALF   = 4 * SCK_HALF_MIN;
    localparam int         BYTE_BITS   = 8;
    localparam int         HDR_BYTES   = 2;
endpackage : spi_reg_pkg

// ===== logic/spi_link_if.sv
// serial link wires between the master end and the register end
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
    logic slave_select_n;
    logic serial_clock_in;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_oe;
    logic miso_level;
    // undriven data out line floats high through a pull-up
    assign miso_level = serial_data_out_oe ? serial_data_out : 1'b1;
    modport dev (
        input  slave_select_n,
        input  serial_clock_in,
        input  serial_data_in,
        output serial_data_out,
        output serial_data_out_oe
    );
    modport host (
        output slave_select_n,
        output serial_clock_in,
        output serial_data_in,
        input  miso_level
    );
endinterface : spi_link_if
`default_nettype wire

// ===== logic/spi_reg_slave.sv
// register end: serial slave port onto the 128 configuration registers
//
// Overview of operation
// - only read 03 and write 02 commands
// - burst read increments address, sends next byte
// - master ends burst read by raising select
// - burst write increments address, stores next byte
// - master ends burst write by raising select
// - address counter wraps from 127 to 0
// - master serial clock at most 5 MHz
// - port active only when strap reads 10
// - start bit cleared by reset
// - start bit is set-only until reset
// - software configures before setting start bit
// - other settings stay writable after start
// - drive on falling, sample on rising edge
// - all 128 registers, 110-120 indirect tables
`timescale 1ns/1ps
`default_nettype none
module spi_reg_slave
    import spi_reg_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // serial link
    spi_link_if.dev                link,
    // strap
    input  wire logic [1:0]        interface_select_strap,
    // switch core side
    output logic                   start_switch,
    output logic                   cfg_wr_stb,
    output logic [ADDR_W-1:0]      cfg_wr_addr,
    output logic [7:0]             cfg_wr_data,
    output logic                   table_rd_stb,
    output logic [ADDR_W-1:0]      table_rd_addr,
    input  wire logic [7:0]        table_rd_data
);
    // ------------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE   = 7'h01,
        S_CMD    = 7'h02,
        S_ADR_RD = 7'h04,
        S_ADR_WR = 7'h08,
        S_RDATA  = 7'h10,
        S_WDATA  = 7'h20,
        S_IGNORE = 7'h40
    } slave_state_t;

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic              sck_prev_ff;
    logic [1:0]        strap_wait_ff;
    logic [1:0]        nxt_strap_wait;
    logic              port_on_ff;
    logic              nxt_port_on;
    slave_state_t      st_ff;
    slave_state_t      nxt_st;
    logic [2:0]        cnt_ff;
    logic [2:0]        nxt_cnt;
    logic [7:0]        rx_ff;
    logic [7:0]        nxt_rx;
    logic [7:0]        tx_ff;
    logic [7:0]        nxt_tx;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic              sdo_ff;
    logic              nxt_sdo;
    logic              oe_ff;
    logic              nxt_oe;
    logic              wr_stb_ff;
    logic              nxt_wr_stb;
    logic [ADDR_W-1:0] wr_addr_ff;
    logic [ADDR_W-1:0] nxt_wr_addr;
    logic [7:0]        wr_data_ff;
    logic [7:0]        nxt_wr_data;
    logic [7:0]        mem_ff [REG_COUNT];

    logic              sel_n;
    logic              sck_rise;
    logic              sck_fall;
    logic [7:0]        rx_byte;
    logic              byte_done;
    logic [ADDR_W-1:0] look_addr;
    logic              look_tbl;
    logic [7:0]        rd_byte;
    logic              fetch;
    logic [ADDR_W-1:0] addr_inc;

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------
    // two stages for every pin, edge detect reads the second stage only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff    <= SYNC_RESET;
            sync2_ff    <= SYNC_RESET;
            sck_prev_ff <= 1'b0;
        end else begin
            sync1_ff    <= {interface_select_strap, link.serial_data_in,
                            link.serial_clock_in, link.slave_select_n};
            sync2_ff    <= sync1_ff;
            sck_prev_ff <= sync2_ff[SY_SCK];
        end
    end

    assign sel_n     = sync2_ff[SY_SEL];
    assign sck_rise  = sync2_ff[SY_SCK] & ~sck_prev_ff;
    assign sck_fall  = ~sync2_ff[SY_SCK] & sck_prev_ff;
    assign rx_byte   = {rx_ff[6:0], sync2_ff[SY_SDI]};
    assign byte_done = sck_rise && (cnt_ff == 3'h7);
    assign addr_inc  = addr_ff + 7'h01;

    // ------------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------------
    // wait for the synchroniser to fill, then latch the strap once
    always_comb begin
        nxt_strap_wait = strap_wait_ff;
        nxt_port_on    = port_on_ff;
        if (strap_wait_ff != STRAP_WAIT) begin
            nxt_strap_wait = strap_wait_ff + 2'h1;
            if (strap_wait_ff == STRAP_WAIT - 2'h1) begin
                nxt_port_on = (sync2_ff[SY_STRAP +: 2] == STRAP_SPI);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_wait_ff <= 2'h0;
            port_on_ff    <= 1'b0;
        end else begin
            strap_wait_ff <= nxt_strap_wait;
            port_on_ff    <= nxt_port_on;
        end
    end

    // ------------------------------------------------------------------
    // read data source
    // ------------------------------------------------------------------
    // addresses 110..120 read from the indirect table port
    assign look_tbl      = (look_addr >= TABLE_FIRST) && (look_addr <= TABLE_LAST);
    assign rd_byte       = look_tbl ? table_rd_data : mem_ff[look_addr];
    assign table_rd_addr = look_addr;
    assign table_rd_stb  = fetch && look_tbl;

    // ------------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st      = st_ff;
        nxt_cnt     = cnt_ff;
        nxt_rx      = rx_ff;
        nxt_tx      = tx_ff;
        nxt_addr    = addr_ff;
        nxt_sdo     = sdo_ff;
        nxt_oe      = oe_ff;
        nxt_wr_stb  = 1'b0;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        look_addr   = addr_inc;
        fetch       = 1'b0;
        // select high drops any partial byte and frees the line
        if (sel_n || !port_on_ff) begin
            nxt_st  = S_IDLE;
            nxt_cnt = 3'h0;
            nxt_oe  = 1'b0;
        end else begin
            if (sck_rise) begin
                nxt_rx  = rx_byte;
                nxt_cnt = cnt_ff + 3'h1;
            end
            case (st_ff)
                S_IDLE: begin
                    nxt_st = S_CMD;
                end
                S_CMD: begin
                    if (byte_done) begin
                        if (rx_byte == CMD_READ) begin
                            nxt_st = S_ADR_RD;
                        end else if (rx_byte == CMD_WRITE) begin
                            nxt_st = S_ADR_WR;
                        end else begin
                            nxt_st = S_IGNORE;
                        end
                    end
                end
                S_ADR_RD: begin
                    look_addr = rx_byte[ADDR_W-1:0];
                    if (byte_done) begin
                        nxt_addr = rx_byte[ADDR_W-1:0];
                        nxt_tx   = rd_byte;
                        fetch    = 1'b1;
                        nxt_st   = S_RDATA;
                    end
                end
                S_ADR_WR: begin
                    if (byte_done) begin
                        nxt_addr = rx_byte[ADDR_W-1:0];
                        nxt_st   = S_WDATA;
                    end
                end
                S_RDATA: begin
                    if (byte_done) begin
                        nxt_addr = addr_inc;
                        nxt_tx   = rd_byte;
                        fetch    = 1'b1;
                    end
                    // output bit changes on falling edge
                    if (sck_fall) begin
                        nxt_sdo = tx_ff[~cnt_ff];
                        nxt_oe  = 1'b1;
                    end
                end
                S_WDATA: begin
                    // store byte, move to next register
                    if (byte_done) begin
                        nxt_wr_stb  = 1'b1;
                        nxt_wr_addr = addr_ff;
                        nxt_wr_data = rx_byte;
                        // start bit cannot be cleared by a write
                        if (addr_ff == START_REG) begin
                            nxt_wr_data[START_BIT] = rx_byte[START_BIT] | mem_ff[START_REG][START_BIT];
                        end
                        // seven-bit counter rolls 127 to 0
                        nxt_addr = addr_inc;
                    end
                end
                S_IGNORE: begin
                    nxt_oe = 1'b0;
                end
                default: begin
                    nxt_st = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff      <= S_IDLE;
            cnt_ff     <= 3'h0;
            rx_ff      <= 8'h00;
            tx_ff      <= 8'h00;
            addr_ff    <= 7'h00;
            sdo_ff     <= 1'b0;
            oe_ff      <= 1'b0;
            wr_stb_ff  <= 1'b0;
            wr_addr_ff <= 7'h00;
            wr_data_ff <= 8'h00;
        end else begin
            st_ff      <= nxt_st;
            cnt_ff     <= nxt_cnt;
            rx_ff      <= nxt_rx;
            tx_ff      <= nxt_tx;
            addr_ff    <= nxt_addr;
            sdo_ff     <= nxt_sdo;
            oe_ff      <= nxt_oe;
            wr_stb_ff  <= nxt_wr_stb;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    // reset clears all registers, start bit included
    // every other bit takes writes at any time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem_ff[i] <= REG_RESET;
            end
        end else if (nxt_wr_stb) begin
            mem_ff[nxt_wr_addr] <= nxt_wr_data;
        end
    end

    // outputs
    assign start_switch            = mem_ff[START_REG][START_BIT];
    assign cfg_wr_stb              = wr_stb_ff;
    assign cfg_wr_addr             = wr_addr_ff;
    assign cfg_wr_data             = wr_data_ff;
    assign link.serial_data_out    = sdo_ff;
    assign link.serial_data_out_oe = oe_ff;
endmodule : spi_reg_slave
`default_nettype wire

// ===== logic/spi_reg_master.sv
// master end: issues read and write bursts over the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_reg_master
    import spi_reg_pkg::*;
#(
    parameter int HALF = HOST_HALF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // serial link
    spi_link_if.host         link,
    // command request
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [7:0]  cmd_count,
    // write data and read data
    input  wire logic [7:0]  wr_data,
    output logic             wr_take,
    output logic [7:0]       rd_data,
    output logic             rd_valid
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        M_IDLE  = 5'h01,
        M_SETUP = 5'h02,
        M_SHIFT = 5'h04,
        M_HOLD  = 5'h08,
        M_GAP   = 5'h10
    } master_state_t;

    master_state_t st_ff;
    master_state_t nxt_st;
    logic [7:0]  div_ff;
    logic [7:0]  nxt_div;
    logic        sck_ff;
    logic        nxt_sck;
    logic        sel_n_ff;
    logic        nxt_sel_n;
    logic [7:0]  tx_ff;
    logic [7:0]  nxt_tx;
    logic [7:0]  rx_ff;
    logic [7:0]  nxt_rx;
    logic [2:0]  bit_ff;
    logic [2:0]  nxt_bit;
    logic [8:0]  byte_ff;
    logic [8:0]  nxt_byte;
    logic [8:0]  total_ff;
    logic [8:0]  nxt_total;
    logic        wr_ff;
    logic        nxt_wr;
    logic [7:0]  addr_ff;
    logic [7:0]  nxt_addr;
    logic [7:0]  rd_data_ff;
    logic [7:0]  nxt_rd_data;
    logic        rd_valid_ff;
    logic        nxt_rd_valid;
    logic        take;
    logic        miso_s1_ff;
    logic        miso_s2_ff;
    logic        half_end;

    // ------------------------------------------------------------------
    // data line synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            miso_s1_ff <= 1'b1;
            miso_s2_ff <= 1'b1;
        end else begin
            miso_s1_ff <= link.miso_level;
            miso_s2_ff <= miso_s1_ff;
        end
    end

    assign half_end  = (div_ff == 8'(HALF - 1));
    assign cmd_ready = (st_ff == M_IDLE);

    // ------------------------------------------------------------------
    // burst sequencer and clock divider
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_div      = half_end ? 8'h00 : div_ff + 8'h01;
        nxt_sck      = sck_ff;
        nxt_sel_n    = sel_n_ff;
        nxt_tx       = tx_ff;
        nxt_rx       = rx_ff;
        nxt_bit      = bit_ff;
        nxt_byte     = byte_ff;
        nxt_total    = total_ff;
        nxt_wr       = wr_ff;
        nxt_addr     = addr_ff;
        nxt_rd_data  = rd_data_ff;
        nxt_rd_valid = 1'b0;
        take         = 1'b0;
        case (st_ff)
            M_IDLE: begin
                nxt_div = 8'h00;
                if (cmd_valid) begin
                    nxt_st    = M_SETUP;
                    nxt_sel_n = 1'b0;
                    nxt_tx    = cmd_write ? CMD_WRITE : CMD_READ;
                    nxt_wr    = cmd_write;
                    nxt_addr  = cmd_addr;
                    nxt_total = 9'(cmd_count) + 9'(HDR_BYTES);
                    nxt_bit   = 3'h0;
                    nxt_byte  = 9'h000;
                end
            end
            M_SETUP: begin
                if (half_end) begin
                    nxt_st = M_SHIFT;
                end
            end
            // one half period is at least 100 ns
            M_SHIFT: begin
                if (half_end) begin
                    nxt_sck = ~sck_ff;
                    if (!sck_ff) begin
                        nxt_rx  = {rx_ff[6:0], miso_s2_ff};
                        nxt_bit = bit_ff + 3'h1;
                        if (bit_ff == 3'(BYTE_BITS - 1)) begin
                            nxt_byte = byte_ff + 9'h001;
                            if (!wr_ff && byte_ff >= 9'(HDR_BYTES)) begin
                                nxt_rd_data  = {rx_ff[6:0], miso_s2_ff};
                                nxt_rd_valid = 1'b1;
                            end
                        end
                    end else if (bit_ff != 3'h0) begin
                        // drive next bit on falling edge
                        nxt_tx = {tx_ff[6:0], 1'b0};
                    end else if (byte_ff == total_ff) begin
                        nxt_st = M_HOLD;
                    end else if (byte_ff == 9'h001) begin
                        nxt_tx = addr_ff;
                    end else if (wr_ff) begin
                        nxt_tx = wr_data;
                        take   = 1'b1;
                    end else begin
                        nxt_tx = 8'h00;
                    end
                end
            end
            // select raised on a byte boundary ends the burst
            M_HOLD: begin
                if (half_end) begin
                    nxt_st    = M_GAP;
                    nxt_sel_n = 1'b1;
                end
            end
            M_GAP: begin
                if (half_end) begin
                    nxt_st = M_IDLE;
                end
            end
            default: begin
                nxt_st = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff       <= M_IDLE;
            div_ff      <= 8'h00;
            sck_ff      <= 1'b0;
            sel_n_ff    <= 1'b1;
            tx_ff       <= 8'h00;
            rx_ff       <= 8'h00;
            bit_ff      <= 3'h0;
            byte_ff     <= 9'h000;
            total_ff    <= 9'h000;
            wr_ff       <= 1'b0;
            addr_ff     <= 8'h00;
            rd_data_ff  <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            div_ff      <= nxt_div;
            sck_ff      <= nxt_sck;
            sel_n_ff    <= nxt_sel_n;
            tx_ff       <= nxt_tx;
            rx_ff       <= nxt_rx;
            bit_ff      <= nxt_bit;
            byte_ff     <= nxt_byte;
            total_ff    <= nxt_total;
            wr_ff       <= nxt_wr;
            addr_ff     <= nxt_addr;
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // outputs
    assign link.slave_select_n  = sel_n_ff;
    assign link.serial_clock_in = sck_ff;
    assign link.serial_data_in  = tx_ff[7];
    assign wr_take              = take;
    assign rd_data              = rd_data_ff;
    assign rd_valid             = rd_valid_ff;
endmodule : spi_reg_master
`default_nettype wire

// ===== tb/spi_link_monitor.sv
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module spi_link_monitor (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // link wires
    input  wire logic slave_select_n,
    input  wire logic serial_clock_in,
    input  wire logic serial_data_in,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe
);
    logic       sck_ff, nxt_sck;
    logic [7:0] rise_cnt_ff, nxt_rise_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // rising serial clocks since select fell
    always_comb begin
        nxt_sck = serial_clock_in;
        nxt_rise_cnt = slave_select_n ? 8'h00 : rise_cnt_ff + {7'h00, serial_clock_in & ~sck_ff};
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_ff <= 1'b0;
            rise_cnt_ff <= 8'h00;
        end else begin
            sck_ff <= nxt_sck;
            rise_cnt_ff <= nxt_rise_cnt;
        end
    end
    a_sck_in_frame: assert property (serial_clock_in |-> !slave_select_n)
        else $error("serial clock high outside a frame");
    a_select_setup: assert property ($fell(slave_select_n) |-> !serial_clock_in [*8])
        else $error("serial clock rose too soon after select");
    a_sck_half_time: assert property ($rose(serial_clock_in) |-> serial_clock_in [*8] ##1 !serial_clock_in)
        else $error("serial clock high time wrong");
    a_sdi_held_high: assert property (serial_clock_in && sck_ff |-> $stable(serial_data_in))
        else $error("master data moved while clock high");
    a_sdo_held_high: assert property (serial_data_out_oe && serial_clock_in && sck_ff |-> $stable(serial_data_out))
        else $error("slave data moved while clock high");
    a_oe_after_header: assert property ($rose(serial_data_out_oe) |-> rise_cnt_ff == 8'h10 && !slave_select_n)
        else $error("slave drove before header was complete");
    a_oe_release: assert property (slave_select_n [*5] |-> !serial_data_out_oe)
        else $error("slave still drives after select high");
    a_whole_bytes: assert property ($rose(slave_select_n) |-> rise_cnt_ff[2:0] == 3'h0 && rise_cnt_ff != 8'h00)
        else $error("frame ended mid byte");
    c_read_frame: cover property ($rose(serial_data_out_oe));
    c_long_burst: cover property ($rose(slave_select_n) && rise_cnt_ff > 8'h20);
    c_write_byte: cover property (!serial_data_out_oe && rise_cnt_ff == 8'h18);
endmodule : spi_link_monitor
`default_nettype wire

// ===== tb/spi_slave_register_access_tb.sv
// self-checking bench: master end drives bursts into the register end
`timescale 1ns/1ps
`default_nettype none
module spi_slave_register_access_tb import spi_reg_pkg::*;;
    logic        clk, rst, cmd_valid, cmd_ready, cmd_write, wr_take, rd_valid, start_switch, cfg_wr_stb, table_rd_stb;
    logic [1:0]  strap;
    logic [6:0]  cfg_wr_addr, table_rd_addr;
    logic [7:0]  cmd_addr, cmd_count, wr_data, rd_data, cfg_wr_data, table_rd_data, src_q[$], rd_q[$];
    logic [7:0]  mem [REG_COUNT];
    logic [14:0] st_q[$];
    int          n_mismatch, cmp_count, cycles, n_tbl;
    assign table_rd_data = {1'b1, table_rd_addr};
    spi_link_if link ();
    spi_reg_master #(.HALF(8)) spi_reg_master_i (.clk(clk), .rst(rst), .link(link.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
        .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid));
    spi_reg_slave spi_reg_slave_i (.clk(clk), .rst(rst), .link(link.dev), .interface_select_strap(strap),
        .start_switch(start_switch), .cfg_wr_stb(cfg_wr_stb), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data),
        .table_rd_stb(table_rd_stb), .table_rd_addr(table_rd_addr), .table_rd_data(table_rd_data));
    spi_link_monitor spi_link_monitor_i (.clk(clk), .rst(rst), .slave_select_n(link.slave_select_n),
        .serial_clock_in(link.serial_clock_in), .serial_data_in(link.serial_data_in),
        .serial_data_out(link.serial_data_out), .serial_data_out_oe(link.serial_data_out_oe));
    // ----------------------------------------
    // compare and closing tasks
    // ----------------------------------------
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_store(input logic [14:0] got, input logic [14:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_store
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // one burst: notes expectations, then issues the command (v < 0 gives random data)
    task automatic xfer(input logic w, input logic [7:0] a, input int n, input int v);
        logic [6:0] r;
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            r = a[6:0] + 7'(i);
            d = (v < 0) ? 8'($urandom) : 8'(v);
            if (w) begin
                src_q.push_back(d);
                // start bit is set-only, so the stored byte keeps an earlier one
                mem[r] = (r == START_REG) ? (d | {7'h00, mem[r][0]}) : d;
                st_q.push_back({r, mem[r]});
            end else begin
                rd_q.push_back((r >= TABLE_FIRST && r <= TABLE_LAST) ? {1'b1, r} : mem[r]);
            end
        end
        wr_data = src_q.size() ? src_q[0] : 8'h00;
        cmd_write = w;
        cmd_addr = a;
        cmd_count = 8'(n);
        cmd_valid = 1'b1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        do begin
            @(posedge clk);
            #1;
        end while (cmd_ready !== 1'b1);
    endtask : xfer
    // ----------------------------------------
    // clock, watchers and sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            end_of_test();
        end
        if (rd_valid === 1'b1) begin
            cmp_byte(rd_data, rd_q.size() ? rd_q.pop_front() : 8'hXX);
        end
        if (cfg_wr_stb === 1'b1) begin
            cmp_store({cfg_wr_addr, cfg_wr_data}, st_q.size() ? st_q.pop_front() : 15'hXXXX);
        end
        // one table fetch strobe per indirect register read
        if (table_rd_stb === 1'b1) begin
            n_tbl++;
        end
    end
    always @(posedge clk) begin
        if (wr_take === 1'b1) begin
            #1 void'(src_q.pop_front());
            wr_data = src_q.size() ? src_q[0] : 8'h00;
        end
    end
    initial begin
        rst = 1'b1;
        strap = STRAP_SPI;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 8'h00;
        cmd_count = 8'h00;
        wr_data = 8'h00;
        n_mismatch = 0;
        cmp_count = 0;
        cycles = 0;
        n_tbl = 0;
        foreach (mem[i]) mem[i] = REG_RESET;
        void'($urandom(32'h6B3DC64A));
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1 cmp_byte({7'h00, start_switch}, 8'h00);
        xfer(1'b1, 8'h7E, 3, -1);
        xfer(1'b1, 8'h01, 1, 8'h01);
        cmp_byte({7'h00, start_switch}, 8'h01);
        xfer(1'b1, 8'h81, 2, 8'h00);
        cmp_byte({7'h00, start_switch}, 8'h01);
        xfer(1'b1, 8'($urandom), 20, -1);
        xfer(1'b0, 8'h7C, 8, -1);
        xfer(1'b0, 8'h05, REG_COUNT + 2, -1);
        cmp_byte(8'(rd_q.size() + st_q.size()), 8'h00);
        cmp_byte(8'(n_tbl), 8'(TABLE_LAST - TABLE_FIRST + 7'h01));
        end_of_test();
    end
endmodule : spi_slave_register_access_tb
`default_nettype wire
